// File: bench/mb_master.sv
// Serial master model: sends request characters and collects reply characters
`timescale 1ns/1ps
module mb_master
  import mb_pkg::*;
#(
  parameter int BIT_T = BIT_CYC_I
)
(
  // Clock
  input wire logic clk,
  // Serial line
  output logic     line_rx,
  input wire logic line_tx,
  input wire logic line_oe
);
  // Line rests at mark level between frames
  initial line_rx = 1'b1;

  // One 8N1 character, LSB first, one bit per BIT_T clocks
  task automatic put_byte(input logic [7:0] b);
    logic [9:0] w;
    w = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      line_rx = w[i];
      repeat (BIT_T - 1) @(negedge clk);
    end
  endtask

  // Waits for the reply, then samples each character mid-bit
  task automatic get_reply(output logic [7:0] q[$], output bit ok);
    int          n;
    logic [7:0]  b;
    q = {};
    ok = 1'b0;
    n = 0;
    while (line_oe !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (line_oe !== 1'b1)
      return;
    ok = 1'b1;
    forever
    begin
      n = 0;
      // Bounded so a stuck driver cannot hang the master
      while (line_tx !== 1'b0 && line_oe === 1'b1 && n < 2000)
      begin
        @(posedge clk);
        n++;
      end
      if (line_oe !== 1'b1 || n >= 2000)
        break;
      repeat (BIT_T / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_T) @(posedge clk);
        b[i] = line_tx;
      end
      repeat (BIT_T) @(posedge clk);
      if (line_tx !== 1'b1)
        ok = 1'b0;
      q.push_back(b);
    end
  endtask
endmodule

// File: bench/test_modbus_slave.sv
// Self-checking bench for the serial register-access slave
`timescale 1ns/1ps
module test_modbus_slave
  import mb_pkg::*;
;
  localparam int T35_T   = 700;
  localparam int BLINK_T = 50;
  // Bit time cut tenfold so six exchanges fit the cycle budget
  localparam int BIT_T   = 52;
  logic        clk = 1'b0;
  logic        rst;
  logic [7:0]  sa;
  logic        line_rx, line_tx, line_oe;
  logic [15:0] pm_addr, pm_rdata, pm_wdata;
  logic        pm_rd, pm_input, pm_wr, led_rx, led_tx;
  int          bad_count = 0, compares = 0, cyc = 0;
  int          wr_n, rd_n, rx_hi, tx_hi, oe_hi, idle_bad;
  logic [15:0] lfsr_r, w_addr, w_data, r_addr, off, dat;
  logic        w_in, r_in;
  logic [7:0]  fa;
  logic [15:0] map [256];

  // 100 ns clock
  always #50 clk = ~clk;

  modbus_slave #(.T35_CYCLES(T35_T), .BLINK_CYCLES(BLINK_T), .BIT_CYCLES(BIT_T)) DUT (
    .clk(clk), .rst(rst), .slave_addr(sa), .line_rx(line_rx), .line_tx(line_tx),
    .line_oe(line_oe), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_input(pm_input),
    .pm_rdata(pm_rdata), .pm_wr(pm_wr), .pm_wdata(pm_wdata), .led_rx(led_rx),
    .led_tx(led_tx));
  mb_master #(.BIT_T(BIT_T)) master (
    .clk(clk), .line_rx(line_rx), .line_tx(line_tx), .line_oe(line_oe));

  // Parameter map: same-cycle read, written on each pulse
  assign pm_rdata = map[pm_addr[7:0]];

  // Monitor of map accesses, lamps and line idle level
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (pm_wr === 1'b1)
    begin
      map[pm_addr[7:0]] <= pm_wdata;
      wr_n <= wr_n + 1;
      w_addr <= pm_addr;
      w_data <= pm_wdata;
      w_in <= pm_input;
    end
    if (pm_rd === 1'b1)
    begin
      rd_n <= rd_n + 1;
      r_addr <= pm_addr;
      r_in <= pm_input;
    end
    rx_hi <= rx_hi + int'(led_rx === 1'b1);
    tx_hi <= tx_hi + int'(led_tx === 1'b1);
    oe_hi <= oe_hi + int'(line_oe === 1'b1);
    idle_bad <= idle_bad + int'(rst === 1'b0 && line_oe === 1'b0 && line_tx !== 1'b1);
    // Ceiling well above the six exchanges (about 44k cycles)
    if (cyc > 80000)
    begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction

  // Independent CRC-16, reflected, preset all ones
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic clr_mon();
    wr_n = 0;
    rd_n = 0;
    rx_hi = 0;
    tx_hi = 0;
    oe_hi = 0;
  endtask

  // Request with CRC appended low byte first
  task automatic send_frame(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    clr_mon();
    foreach (q[i]) master.put_byte(q[i]);
  endtask

  task automatic expect_reply(input logic [7:0] e[$]);
    logic [7:0]  r[$];
    logic [15:0] c;
    bit          ok;
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    master.get_reply(r, ok);
    check("reply framing", 16'(ok), 16'h0001);
    check("reply length", 16'(r.size()), 16'(e.size()));
    foreach (e[i]) if (i < r.size()) check("reply byte", {8'h00, r[i]}, {8'h00, e[i]});
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence: reset, broadcast write, input read-back, block write,
  // foreign station, count over limit, unknown function
  initial
  begin
    rst = 1'b1;
    idle_bad = 0;
    lfsr_r = 16'h3400;
    for (int i = 0; i < 256; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      map[i] = lfsr_r;
    end
    sa = 8'(lfsr_r % 247) + 8'h01;
    clr_mon();
    repeat (16) @(posedge clk);
    @(negedge clk);
    check("tx idle in reset", {15'h0000, line_tx}, 16'h0001);
    check("oe in reset", {15'h0000, line_oe}, 16'h0000);
    check("strobes in reset", {14'h0000, pm_rd, pm_wr}, 16'h0000);
    check("lamps in reset", {14'h0000, led_rx, led_tx}, 16'h0000);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    // Broadcast write of a random value: executed, never answered
    lfsr_r = lfsr_next(lfsr_r);
    off = {8'h00, lfsr_r[7:0]};
    lfsr_r = lfsr_next(lfsr_r);
    dat = lfsr_r;
    send_frame('{8'h00, FC_WR_ONE, 8'h00, off[7:0], dat[15:8], dat[7:0]});
    repeat (T35_T + 300) @(negedge clk);
    check("write count", 16'(wr_n), 16'h0001);
    check("write offset", w_addr, off);
    check("write data", w_data, dat);
    check("write space", {15'h0000, w_in}, 16'h0000);
    check("broadcast silent", 16'(oe_hi), 16'h0000);
    check("rx lamp active", 16'(rx_hi > 0), 16'h0001);
    $display("test broadcast write done");
    // Same offset read through the input space returns the written value
    send_frame('{sa, FC_RD_INPUT, 8'h00, off[7:0], 8'h00, 8'h01});
    expect_reply('{sa, FC_RD_INPUT, 8'h02, dat[15:8], dat[7:0]});
    check("read count", 16'(rd_n), 16'h0001);
    check("read space", {15'h0000, r_in}, 16'h0001);
    check("read offset", r_addr, off);
    check("no write on read", 16'(wr_n), 16'h0000);
    check("tx lamp active", 16'(tx_hi > 0), 16'h0001);
    $display("test input read done");
    // Block write of two random words to the own station, echoed back
    lfsr_r = lfsr_next(lfsr_r);
    off = {9'h000, lfsr_r[6:0]};
    dat = lfsr_next(lfsr_r);
    send_frame('{sa, FC_WR_MANY, 8'h00, off[7:0], 8'h00, 8'h02, 8'h04,
                 lfsr_r[15:8], lfsr_r[7:0], dat[15:8], dat[7:0]});
    expect_reply('{sa, FC_WR_MANY, 8'h00, off[7:0], 8'h00, 8'h02});
    check("block write count", 16'(wr_n), 16'h0002);
    check("block first word", map[off[7:0]], lfsr_r);
    check("block last offset", w_addr, off + 16'h0001);
    check("block last word", w_data, dat);
    check("block write space", {15'h0000, w_in}, 16'h0000);
    $display("test block write done");
    // A frame for another station is ignored: no reply, no access
    fa = (sa == MAX_SLAVE) ? 8'h01 : sa + 8'h01;
    send_frame('{fa, FC_RD_HOLD, 8'h00, off[7:0], 8'h00, 8'h01});
    repeat (T35_T + 300) @(negedge clk);
    check("foreign silent", 16'(oe_hi), 16'h0000);
    check("foreign no access", 16'(rd_n + wr_n), 16'h0000);
    // Count above the limit draws exception 03 with no map access
    send_frame('{sa, FC_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'({1'b0, MAX_REGS}) + 8'h01});
    expect_reply('{sa, FC_RD_HOLD | EXC_FLAG, EXC_DATA});
    check("no read over limit", 16'(rd_n + wr_n), 16'h0000);
    $display("test foreign and limit done");
    // Unknown function code draws exception 01 with no map access
    send_frame('{sa, 8'h2b});
    expect_reply('{sa, 8'hab, EXC_FUNC});
    check("no access on exception", 16'(rd_n + wr_n), 16'h0000);
    repeat (3 * BLINK_T) @(negedge clk);
    check("lamps off when quiet", {14'h0000, led_rx, led_tx}, 16'h0000);
    check("tx idle level", 16'(idle_bad), 16'h0000);
    $display("test exception done");
    test_done();
  end
endmodule

// File: core/crc16_unit.sv
// Byte-wide CRC-16 engine, reflected polynomial
`timescale 1ns/1ps
module crc16_unit
  import mb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Engine side of the CRC link
  crc_if.engine    cb
);
  logic [15:0] crc_r;

  // One whole byte per cycle; the loop unrolls into eight shift stages
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  // Init wins over feed so a stale byte never leaks into a new frame
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crc_r <= CRC_INIT;
    else if (cb.init)
      crc_r <= CRC_INIT;
    else if (cb.feed)
      crc_r <= crc_step(crc_r, cb.data);
  end

  assign cb.crc = crc_r;
endmodule

// File: core/crc_if.sv
// Link between frame logic and CRC engine
`timescale 1ns/1ps
interface crc_if;
  logic        init;
  logic        feed;
  logic [7:0]  data;
  logic [15:0] crc;
  modport user (output init, output feed, output data, input crc);
  modport engine (input init, input feed, input data, output crc);
endinterface

// File: core/mb_pkg.sv
// Constants, encodings and types shared by the serial slave and its CRC engine
package mb_pkg;
  // Clocking and line timing
  localparam int         CLK_HZ    = 10_000_000;
  localparam int         BAUD      = 19_200;
  localparam int         BIT_CYC_I = CLK_HZ / BAUD;
  localparam logic [9:0] BIT_CYC   = 10'(BIT_CYC_I - 1);
  localparam logic [9:0] HALF_BIT  = 10'(BIT_CYC_I / 2);
  localparam logic [3:0] UART_LAST = 4'h9;
  localparam int         T35_US    = 2005;
  localparam int         T35_CYC   = T35_US * (CLK_HZ / 1_000_000);
  localparam int         BLINK_MS  = 250;
  localparam int         BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
  // Addressing and limits
  localparam logic [7:0]  MAX_SLAVE  = 8'hf7;
  localparam logic [7:0]  BCAST      = 8'h00;
  localparam logic [6:0]  MAX_REGS   = 7'h40;
  localparam logic [16:0] PM_WORDS   = 17'h00100;
  localparam int          HOLD_BASE  = 40001;
  localparam int          INPUT_BASE = 30001;
  // Function and exception codes
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_ONE   = 8'h06;
  localparam logic [7:0] FC_WR_MANY  = 8'h10;
  localparam logic [7:0] EXC_FLAG    = 8'h80;
  localparam logic [7:0] EXC_NONE    = 8'h00;
  localparam logic [7:0] EXC_FUNC    = 8'h01;
  localparam logic [7:0] EXC_ADDR    = 8'h02;
  localparam logic [7:0] EXC_DATA    = 8'h03;
  // Frame byte positions and lengths
  localparam logic [7:0] POS_ADDR   = 8'h00;
  localparam logic [7:0] POS_FC     = 8'h01;
  localparam logic [7:0] POS_BC     = 8'h02;
  localparam logic [7:0] POS_DATA   = 8'h07;
  localparam logic [7:0] POS_RDATA  = 8'h03;
  localparam logic [7:0] LEN_MIN    = 8'h04;
  localparam logic [7:0] LEN_EXC    = 8'h05;
  localparam logic [7:0] LEN_RD_HDR = 8'h05;
  localparam logic [7:0] LEN_FIXED  = 8'h08;
  localparam logic [7:0] LEN_WM_HDR = 8'h09;
  localparam int         RX_MAX     = 137;
  // CRC
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_OK   = 16'h0000;
  typedef enum logic [3:0] {
    S_RX = 4'h0, S_EXEC = 4'h1, S_WR = 4'h2, S_TXB = 4'h3,
    S_FETCH = 4'h4, S_SEND = 4'h5, S_TXW = 4'h6, S_DONE = 4'h7
  } state_t;
  typedef enum logic [1:0] {K_READ = 2'h0, K_WRITE = 2'h1, K_EXC = 2'h2} kind_t;
endpackage

// File: core/modbus_slave.sv
// Serial register-access slave: framing, decode, parameter map access, indicators
// Function
// - Acts as one slave on a half-duplex multidrop line with one master and up to 247 slaves.
// - Executes read-holding (03) and read-input (04) and returns the register contents.
// - Executes write-single (06) and write-block (10) of consecutive registers.
// - No command moves more than 64 registers.
// - Holding registers are read and written; input registers are only read.
// - Both spaces read the same parameter map at the same offset.
// - The line runs at no more than 19200 baud.
// - The receive indicator blinks twice per second while frames are received.
// - The transmit indicator blinks twice per second while replies are sent.
`timescale 1ns/1ps
module modbus_slave
  import mb_pkg::*;
#(
  parameter int T35_CYCLES   = T35_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int BIT_CYCLES   = BIT_CYC_I
)
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Station address
  input wire logic [7:0]  slave_addr,
  // Line transceiver
  input wire logic        line_rx,
  output logic            line_tx,
  output logic            line_oe,
  // Parameter map
  output logic [15:0]     pm_addr,
  output logic            pm_rd,
  output logic            pm_input,
  input wire logic [15:0] pm_rdata,
  output logic            pm_wr,
  output logic [15:0]     pm_wdata,
  // Indicators
  output logic            led_rx,
  output logic            led_tx
);
  state_t      state_r;
  kind_t       kind_r;
  logic [2:0]  rx_s_r;
  logic        rx_q_r, rxu_busy_r, rx_stb_r, rx_ferr_r;
  logic [9:0]  rxu_tmr_r, txu_tmr_r;
  logic [3:0]  rxu_bit_r, txu_bit_r;
  logic [7:0]  rxu_sh_r, rx_byte_r, cnt_r, fc_r, exc_r, idx_r, nb_r, txb, rel;
  logic [7:0]  buf_r [0:RX_MAX-1];
  logic        bad_r, bc_r, txu_busy_r, line_tx_r, line_oe_r, txu_done, need_fetch;
  logic [15:0] gap_r, st_r, word_r, pm_addr_r, pm_wdata_r, f_st, f_qty;
  logic [16:0] f_end;
  logic [6:0]  qty_r, widx_r;
  logic [9:0]  txu_sh_r;
  logic [21:0] blink_r;
  logic [1:0]  act, seen_r, led_r;
  logic        pm_rd_r, pm_wr_r, pm_input_r, frame_end, tick, acc_stb;
  logic        is_rd, is_w1, is_wm, addressed, bcast, len_ok, crc_ok;
  logic [7:0]  exc_c;
  crc_if       cb ();

  // Bit timing: the default is the line rate; a shorter one only speeds up a bench
  localparam logic [9:0] BIT_RELOAD = 10'(BIT_CYCLES - 1);
  localparam logic [9:0] BIT_MID    = 10'(BIT_CYCLES / 2);

  crc16_unit u_crc (.clk(clk), .rst(rst), .cb(cb));

  // Three-stage pin sync; level moves only when stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_s_r <= 3'h7;
      rx_q_r <= 1'b1;
    end
    else
    begin
      rx_s_r <= {rx_s_r[1:0], line_rx};
      if (rx_s_r[1] == rx_s_r[2])
        rx_q_r <= rx_s_r[2];
    end
  end

  // Receiver: mid-bit sampling; start only armed while listening (half duplex)
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxu_busy_r <= 1'b0;
      rxu_tmr_r  <= 10'h000;
      rxu_bit_r  <= 4'h0;
      rxu_sh_r   <= 8'h00;
      rx_stb_r   <= 1'b0;
      rx_ferr_r  <= 1'b0;
      rx_byte_r  <= 8'h00;
    end
    else
    begin
      rx_stb_r  <= 1'b0;
      rx_ferr_r <= 1'b0;
      if (!rxu_busy_r)
      begin
        if (!rx_q_r && state_r == S_RX)
        begin
          rxu_busy_r <= 1'b1;
          rxu_tmr_r  <= BIT_MID;
          rxu_bit_r  <= 4'h0;
        end
      end
      else if (rxu_tmr_r != 10'h000)
        rxu_tmr_r <= rxu_tmr_r - 10'h001;
      else
      begin
        rxu_tmr_r <= BIT_RELOAD;
        rxu_bit_r <= rxu_bit_r + 4'h1;
        if (rxu_bit_r == 4'h0 && rx_q_r)
          rxu_busy_r <= 1'b0; // Glitch, not a start bit
        else if (rxu_bit_r == UART_LAST)
        begin
          rxu_busy_r <= 1'b0;
          rx_stb_r   <= rx_q_r;
          rx_ferr_r  <= !rx_q_r;
          rx_byte_r  <= rxu_sh_r;
        end
        else if (rxu_bit_r != 4'h0)
          rxu_sh_r <= {rx_q_r, rxu_sh_r[7:1]};
      end
    end
  end

  assign acc_stb   = rx_stb_r && state_r == S_RX;
  assign frame_end = state_r == S_RX && cnt_r != 8'h00 && !rxu_busy_r
                     && gap_r == 16'(T35_CYCLES);

  // Frame length, error flag and silence timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 8'h00;
      bad_r <= 1'b0;
      gap_r <= 16'h0000;
    end
    else if (state_r == S_DONE)
    begin
      cnt_r <= 8'h00;
      bad_r <= 1'b0;
      gap_r <= 16'h0000;
    end
    else if (acc_stb)
    begin
      gap_r <= 16'h0000;
      if (cnt_r < 8'(RX_MAX))
        cnt_r <= cnt_r + 8'h01;
      else
        bad_r <= 1'b1;
    end
    else if (rx_ferr_r || rxu_busy_r)
    begin
      bad_r <= bad_r | rx_ferr_r;
      gap_r <= 16'h0000;
    end
    else if (gap_r != 16'(T35_CYCLES))
      gap_r <= gap_r + 16'h0001;
  end

  // Frame store; plain data, no reset needed
  always_ff @(posedge clk)
  begin
    if (acc_stb && cnt_r < 8'(RX_MAX))
      buf_r[cnt_r] <= rx_byte_r;
  end

  // Request decode; exception order: function, count, range
  always_comb
  begin
    is_rd     = buf_r[POS_FC] == FC_RD_HOLD || buf_r[POS_FC] == FC_RD_INPUT;
    is_w1     = buf_r[POS_FC] == FC_WR_ONE;
    is_wm     = buf_r[POS_FC] == FC_WR_MANY;
    bcast     = buf_r[POS_ADDR] == BCAST;
    addressed = buf_r[POS_ADDR] == slave_addr && slave_addr != BCAST
                && slave_addr <= MAX_SLAVE;
    crc_ok    = cb.crc == CRC_OK && !bad_r;
    f_st      = {buf_r[2], buf_r[3]}; // Zero-based offset on the wire
    f_qty     = is_w1 ? 16'h0001 : {buf_r[4], buf_r[5]};
    f_end     = {1'b0, f_st} + {1'b0, f_qty};
    if (is_rd || is_w1)
      len_ok = cnt_r == LEN_FIXED;
    else if (is_wm)
      len_ok = cnt_r == 8'(LEN_WM_HDR + buf_r[6]);
    else
      len_ok = cnt_r >= LEN_MIN;
    exc_c = EXC_NONE;
    if (!(is_rd || is_w1 || is_wm))
      exc_c = EXC_FUNC;
    else if (f_qty == 16'h0000 || f_qty > {9'h000, MAX_REGS})
      exc_c = EXC_DATA;
    else if (is_wm && buf_r[6] != {f_qty[6:0], 1'b0})
      exc_c = EXC_DATA;
    else if (f_end > PM_WORDS)
      exc_c = EXC_ADDR;
  end

  // Sequencer: one frame decoded, executed and answered at a time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= S_RX;
      kind_r  <= K_READ;
      fc_r    <= 8'h00;
      exc_r   <= EXC_NONE;
      st_r    <= 16'h0000;
      qty_r   <= 7'h00;
      widx_r  <= 7'h00;
      idx_r   <= 8'h00;
      nb_r    <= 8'h00;
      bc_r    <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_RX:
          if (frame_end)
            state_r <= S_EXEC;
        S_EXEC:
        begin
          fc_r   <= buf_r[POS_FC];
          st_r   <= f_st;
          qty_r  <= f_qty[6:0];
          exc_r  <= exc_c;
          idx_r  <= 8'h00;
          widx_r <= 7'h00;
          bc_r   <= bcast;
          if (!crc_ok || !(addressed || bcast) || !len_ok)
            state_r <= S_DONE;
          else if (exc_c != EXC_NONE)
          begin
            kind_r  <= K_EXC;
            nb_r    <= LEN_EXC;
            state_r <= bcast ? S_DONE : S_TXB;
          end
          else if (is_rd)
          begin
            kind_r  <= K_READ;
            nb_r    <= 8'(LEN_RD_HDR + {f_qty[6:0], 1'b0});
            state_r <= bcast ? S_DONE : S_TXB;
          end
          else
          begin
            kind_r  <= K_WRITE;
            nb_r    <= LEN_FIXED;
            state_r <= S_WR;
          end
        end
        S_WR:
        begin
          widx_r <= widx_r + 7'h01; // One register per cycle
          if (widx_r == qty_r - 7'h01)
            state_r <= bc_r ? S_DONE : S_TXB;
        end
        S_TXB:
          state_r <= need_fetch ? S_FETCH : S_SEND;
        S_FETCH:
          state_r <= S_SEND;
        S_SEND:
          state_r <= S_TXW;
        S_TXW:
          if (txu_done)
          begin
            idx_r   <= idx_r + 8'h01;
            state_r <= (idx_r == nb_r - 8'h01) ? S_DONE : S_TXB;
          end
        S_DONE:
          state_r <= S_RX;
        default:
          state_r <= S_RX;
      endcase
    end
  end

  assign rel        = idx_r - POS_RDATA;
  assign need_fetch = kind_r == K_READ && idx_r >= POS_RDATA && idx_r < nb_r - 8'h02
                      && !rel[0];

  // Parameter map port; writes always land in holding space
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pm_rd_r    <= 1'b0;
      pm_wr_r    <= 1'b0;
      pm_input_r <= 1'b0;
      pm_addr_r  <= 16'h0000;
      pm_wdata_r <= 16'h0000;
      word_r     <= 16'h0000;
    end
    else
    begin
      pm_wr_r <= state_r == S_WR;
      pm_rd_r <= state_r == S_TXB && need_fetch;
      if (state_r == S_WR)
      begin
        pm_input_r <= 1'b0;
        pm_addr_r  <= st_r + {9'h000, widx_r};
        if (fc_r == FC_WR_ONE)
          pm_wdata_r <= {buf_r[4], buf_r[5]};
        else
          pm_wdata_r <= {buf_r[8'(POS_DATA + {widx_r, 1'b0})],
                         buf_r[8'(POS_DATA + {widx_r, 1'b1})]};
      end
      else if (state_r == S_TXB && need_fetch)
      begin
        pm_input_r <= fc_r == FC_RD_INPUT; // Same map, space only flagged
        pm_addr_r  <= st_r + {9'h000, rel[7:1]};
      end
      if (state_r == S_FETCH)
        word_r <= pm_rdata;
    end
  end

  // Reply byte selection
  always_comb
  begin
    txb = buf_r[idx_r];
    if (idx_r == nb_r - 8'h02)
      txb = cb.crc[7:0];
    else if (idx_r == nb_r - 8'h01)
      txb = cb.crc[15:8];
    else if (idx_r == POS_FC)
      txb = (kind_r == K_EXC) ? (fc_r | EXC_FLAG) : fc_r;
    else if (kind_r == K_EXC && idx_r == POS_BC)
      txb = exc_r;
    else if (kind_r == K_READ && idx_r == POS_BC)
      txb = {qty_r, 1'b0};
    else if (kind_r == K_READ && idx_r >= POS_RDATA)
      txb = rel[0] ? word_r[7:0] : word_r[15:8];
  end

  assign cb.init = state_r == S_EXEC || state_r == S_DONE;
  assign cb.feed = acc_stb || (state_r == S_SEND && idx_r < nb_r - 8'h02);
  assign cb.data = acc_stb ? rx_byte_r : txb;
  assign txu_done = txu_busy_r && txu_tmr_r == 10'h000 && txu_bit_r == UART_LAST;

  // Transmitter and driver enable; enable spans the whole reply
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txu_busy_r <= 1'b0;
      txu_sh_r   <= 10'h3ff;
      txu_bit_r  <= 4'h0;
      txu_tmr_r  <= 10'h000;
      line_tx_r  <= 1'b1;
      line_oe_r  <= 1'b0;
    end
    else
    begin
      line_oe_r <= state_r == S_TXB || state_r == S_FETCH || state_r == S_SEND
                   || state_r == S_TXW;
      line_tx_r <= txu_busy_r ? txu_sh_r[0] : 1'b1;
      if (state_r == S_SEND)
      begin
        txu_busy_r <= 1'b1;
        txu_sh_r   <= {1'b1, txb, 1'b0};
        txu_bit_r  <= 4'h0;
        txu_tmr_r  <= BIT_RELOAD;
      end
      else if (txu_busy_r && txu_tmr_r != 10'h000)
        txu_tmr_r <= txu_tmr_r - 10'h001;
      else if (txu_busy_r)
      begin
        txu_tmr_r <= BIT_RELOAD;
        txu_sh_r  <= {1'b1, txu_sh_r[9:1]};
        txu_bit_r <= txu_bit_r + 4'h1;
        if (txu_bit_r == UART_LAST)
          txu_busy_r <= 1'b0;
      end
    end
  end

  // Shared quarter-second tick: toggling at it gives two flashes a second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      blink_r <= 22'h000000;
    else if (tick)
      blink_r <= 22'h000000;
    else
      blink_r <= blink_r + 22'h000001;
  end

  assign tick = blink_r == 22'(BLINK_CYCLES - 1);
  assign act  = {state_r == S_SEND, acc_stb};

  // Indicators: activity seen since the last tick keeps the lamp flashing
  for (genvar i = 0; i < 2; i++)
  begin : g_led
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        seen_r[i] <= 1'b0;
        led_r[i]  <= 1'b0;
      end
      else
      begin
        seen_r[i] <= act[i] | (seen_r[i] & ~tick); // Set beats clear
        if (tick)
          led_r[i] <= seen_r[i] ? ~led_r[i] : 1'b0;
      end
    end
  end

  assign line_tx  = line_tx_r;
  assign line_oe  = line_oe_r;
  assign pm_addr  = pm_addr_r;
  assign pm_rd    = pm_rd_r;
  assign pm_wr    = pm_wr_r;
  assign pm_input = pm_input_r;
  assign pm_wdata = pm_wdata_r;
  assign led_rx   = led_r[0];
  assign led_tx   = led_r[1];

  // Checks
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_fetch_send;
    (state_r == S_FETCH) ##1 (state_r == S_SEND);
  endsequence
  sequence s_exc_start;
    (kind_r == K_EXC && state_r == S_TXB) ##1 (state_r == S_SEND);
  endsequence

  a_foreign_addr: assert property (
    state_r == S_EXEC && !bcast && buf_r[POS_ADDR] != slave_addr |=> state_r == S_DONE)
    else $error("frame for another station was served");
  a_read_fetch: assert property (pm_rd_r |-> kind_r == K_READ ##0 s_fetch_send)
    else $error("read fetch out of sequence");
  a_write_step: assert property (
    state_r == S_WR |=> pm_wr_r && pm_addr_r == st_r + {9'h000, $past(widx_r)})
    else $error("write step missing or misaddressed");
  a_qty_limit: assert property (
    pm_rd_r || pm_wr_r |-> qty_r != 7'h00 && qty_r <= MAX_REGS && kind_r != K_EXC)
    else $error("access with illegal register count");
  a_write_hold: assert property (pm_wr_r |-> !pm_input_r && fc_r != FC_RD_INPUT)
    else $error("write reached input space");
  a_shared_map: assert property (
    pm_rd_r |-> pm_input_r == (fc_r == FC_RD_INPUT) && {1'b0, pm_addr_r} < PM_WORDS)
    else $error("read space flag or offset wrong");
  a_bit_time: assert property (
    txu_busy_r && txu_tmr_r == 10'h000 && txu_bit_r != UART_LAST |=> txu_tmr_r == BIT_RELOAD)
    else $error("bit time not reloaded");
  a_rx_blink: assert property ($changed(led_r[0]) |-> $past(tick))
    else $error("receive lamp changed off tick");
  a_tx_blink: assert property (
    tick && seen_r[1] |=> led_r[1] != $past(led_r[1]))
    else $error("transmit lamp did not flash");
  a_exc_reply: assert property (
    state_r == S_EXEC && crc_ok && addressed && len_ok && exc_c != EXC_NONE
    |=> s_exc_start)
    else $error("exception reply not started");
endmodule
